// >>> rtl/std_pkg.sv
// package for the switch telegram decoder: types, codes and timing constants
package std_pkg;
    // value register geometry
    localparam int          NUM_VALUES   = 6;
    localparam int          VAL_W        = 16;
    localparam logic [2:0]  IDX_CURRENT  = 3'h0;    // current_value
    localparam logic [2:0]  IDX_DURATION = 3'h4;    // press_duration_class
    localparam logic [2:0]  IDX_COUNT    = 3'h5;    // telegrams_since_read
    localparam logic [15:0] VAL_RESET    = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
    // bus function that clears the counter on a current_value read
    localparam logic [7:0]  FN_READ_HOLD = 8'h03;
    // lighting-controller raw codes
    localparam logic [7:0]  LC_AUTO      = 8'h30;
    localparam logic [7:0]  LC_MANUAL    = 8'h10;
    localparam logic [7:0]  LC_DIM_UP    = 8'h70;
    localparam logic [7:0]  LC_DIM_DOWN  = 8'h50;
    // detector and handle data byte patterns
    localparam logic [7:0]  DET_ALARM    = 8'h10;
    localparam logic [7:0]  DET_BATT_LOW = 8'h30;
    localparam logic [7:0]  DET_WATER    = 8'h11;
    localparam logic [1:0]  HDL_CLOSED   = 2'h3;    // data[5:4] closed
    localparam logic [1:0]  HDL_TILTED   = 2'h1;    // data[5:4] tilted up
    // field positions in the first data byte
    localparam int          POS_BOW      = 4;       // energy bow, pressed
    localparam int          POS_R1       = 5;       // first rocker action
    localparam int          POS_SECOND   = 0;       // second action valid
    // press duration timing
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned LONG_MS      = 500;
    localparam int unsigned LONG_CYC     = LONG_MS * (CLK_HZ / 1000);

    // equipment_profile selected for a receive channel
    typedef enum logic [3:0] {
        PROF_UNIVERSAL = 4'h0,
        PROF_PUSH      = 4'h1,
        PROF_ROCKER2   = 4'h2,
        PROF_LIGHT     = 4'h3,
        PROF_ROCKER4   = 4'h4,
        PROF_CARD      = 4'h5,
        PROF_ALARM     = 4'h6,
        PROF_WATER     = 4'h7,
        PROF_HANDLE    = 4'h8
    } std_prof_t;

    // press duration states, one-hot
    typedef enum logic [2:0] {
        DUR_REL   = 3'b001,
        DUR_SHORT = 3'b010,
        DUR_LONG  = 3'b100
    } std_dur_t;

    // per-channel configuration
    typedef struct packed {
        logic [7:0] radio_telegram_type;
        std_prof_t  equipment_profile;
    } std_cfg_t;

    // received telegram strobe with its payload
    typedef struct packed {
        logic       stb;
        logic [7:0] ch;
        logic [7:0] radio_telegram_type;
        logic [7:0] first_data_byte;
        logic [7:0] status;
    } std_tg_t;

    // holding-register read request
    typedef struct packed {
        logic       stb;
        logic [7:0] fn;
        logic [7:0] ch;
        logic [2:0] idx;
    } std_rd_t;
endpackage : std_pkg

// >>> rtl/std_decoder.sv
// switch-class telegram decoder with per-channel value registers
//
// Overview of operation
// RULE1 - push button: 1 pressed, history, fourth reserved
// RULE2 - fifth value: released, short, long press
// RULE3 - sixth value counts telegrams since read
// RULE4 - 2-rocker codes 0..4 with two history
// RULE5 - 4-rocker codes 0..8, A-I through D-0
// RULE6 - rockers: fourth value is second action
// RULE7 - lighting variant stores raw controller code
// RULE8 - lighting variant keeps three earlier codes
// RULE9 - card: inserted flag, prior, rest zero
// RULE10 - alarm detector: alarm and low battery
// RULE11 - water detector: water alert flag
// RULE12 - handle: closed/open/tilted, raw byte copy
// RULE13 - accept only matching radio telegram type
// RULE14 - universal: raw data byte and status
// RULE15 - shift history before writing new value
// RULE16 - FN_READ_HOLD read of current_value clears counter, counter saturates
`timescale 1ns/1ps
`default_nettype none
module std_decoder
    import std_pkg::*;
#(
    parameter int          N_CH     = 4,        // receive channels
    parameter int unsigned LONG_CNT = LONG_CYC  // cycles for a long press
) (
    input  wire logic           i_clk_sys,
    input  wire logic           i_arst_n,
    input  wire std_cfg_t       i_cfg [N_CH],
    input  wire std_tg_t        i_tg,
    input  wire std_rd_t        i_rd,
    output logic                o_rd_valid,
    output logic [VAL_W-1:0]    o_rd_data
);
    localparam int CW = (N_CH > 1) ? $clog2(N_CH) : 1;

    // value slots 0..3 stored, slot 4 from duration state, slot 5 counter
    logic [VAL_W-1:0] val_r   [N_CH][4];
    logic [VAL_W-1:0] val_nxt [N_CH][4];
    logic [VAL_W-1:0] cnt_r   [N_CH];      // telegrams since read
    logic [VAL_W-1:0] cnt_nxt [N_CH];
    std_dur_t         dur_r   [N_CH];      // press duration state
    std_dur_t         dur_nxt [N_CH];
    logic [31:0]      tmr_r   [N_CH];      // press length timer
    logic [31:0]      tmr_nxt [N_CH];
    logic             rd_valid_nxt;
    logic [VAL_W-1:0] rd_data_nxt;

    // profiles that carry a press duration value
    function automatic logic has_dur(input std_prof_t p);
        return (p == PROF_PUSH) || (p == PROF_ROCKER2) ||
               (p == PROF_ROCKER4) || (p == PROF_LIGHT);
    endfunction : has_dur

    // duration state to register value
    function automatic logic [VAL_W-1:0] dur_val(input std_dur_t d);
        case (d)
            DUR_SHORT: return 16'h0001;
            DUR_LONG:  return 16'h0002;
            default:   return 16'h0000;
        endcase
    endfunction : dur_val

    // byte to value register, zero extended
    function automatic logic [VAL_W-1:0] ext(input logic [7:0] b);
        return {8'h00, b};
    endfunction : ext

    // read mux for one value register
    function automatic logic [VAL_W-1:0] read_val(
        input logic [VAL_W-1:0] v [4],
        input logic [VAL_W-1:0] c,
        input std_dur_t         d,
        input std_prof_t        p,
        input logic [2:0]       idx
    );
        logic [VAL_W-1:0] r;
        r = 16'h0000;
        if (idx == IDX_COUNT) begin
            r = (p == PROF_CARD) ? 16'h0000 : c;      // [RULE9] [RULE3]
        end else if (idx == IDX_DURATION) begin
            r = has_dur(p) ? dur_val(d) : 16'h0000;   // [RULE2]
        end else if (idx < IDX_DURATION) begin
            // card slots 2 and 3 read zero even before a telegram
            r = (p == PROF_CARD && idx[1]) ? 16'h0000
                                           : v[idx[1:0]];    // [RULE9]
        end
        return r;
    endfunction : read_val

    // next-state logic: timers, bus reads, then telegram decode
    always_comb begin
        logic [CW-1:0]    ch;
        logic [7:0]       db;
        logic             bow;
        logic             hit;
        std_prof_t        p;
        logic [VAL_W-1:0] nv;
        logic [VAL_W-1:0] v4;
        logic             keep4;
        ch           = '0;
        db           = 8'h00;
        bow          = 1'b0;
        hit          = 1'b0;
        p            = PROF_UNIVERSAL;
        nv           = 16'h0000;
        v4           = 16'h0000;
        keep4        = 1'b0;
        val_nxt      = val_r;
        cnt_nxt      = cnt_r;
        dur_nxt      = dur_r;
        tmr_nxt      = tmr_r;
        rd_valid_nxt = 1'b0;
        rd_data_nxt  = o_rd_data;

        // a held press turns long once the timer runs out
        for (int i = 0; i < N_CH; i++) begin
            if (dur_r[i] == DUR_SHORT) begin
                if (tmr_r[i] >= LONG_CNT - 1) begin
                    dur_nxt[i] = DUR_LONG;                     // [RULE2]
                end else begin
                    tmr_nxt[i] = tmr_r[i] + 32'h0000_0001;
                end
            end
        end

        // holding-register read; unmapped channel or index reads zero
        if (i_rd.stb) begin
            rd_valid_nxt = 1'b1;
            rd_data_nxt  = 16'h0000;
            if ({24'h00_0000, i_rd.ch} < 32'(N_CH)) begin
                ch = i_rd.ch[CW-1:0];
                rd_data_nxt = read_val(val_r[ch], cnt_r[ch], dur_r[ch],
                    i_cfg[ch].equipment_profile, i_rd.idx);
                if (i_rd.idx == IDX_CURRENT && i_rd.fn == FN_READ_HOLD) begin
                    cnt_nxt[ch] = 16'h0000;                    // [RULE16]
                end
            end
        end

        // accepted telegram; placed after the read so its count step wins over a same-cycle clear
        if (i_tg.stb && ({24'h00_0000, i_tg.ch} < 32'(N_CH))) begin
            ch  = i_tg.ch[CW-1:0];
            hit = (i_tg.radio_telegram_type ==
                   i_cfg[ch].radio_telegram_type);            // [RULE13]
        end
        if (hit) begin
            p   = i_cfg[ch].equipment_profile;
            db  = i_tg.first_data_byte;
            bow = db[POS_BOW];
            if (cnt_nxt[ch] != CNT_MAX) begin
                cnt_nxt[ch] = cnt_nxt[ch] + 16'h0001;  // [RULE3] [RULE16]
            end
            // press duration follows the energy bow
            if (has_dur(p)) begin
                if (bow) begin
                    dur_nxt[ch] = DUR_SHORT;                   // [RULE2]
                    tmr_nxt[ch] = 32'h0000_0000;
                end else begin
                    dur_nxt[ch] = DUR_REL;                     // [RULE2]
                end
            end
            case (p)
                PROF_PUSH: begin
                    nv = {15'h0000, bow};                      // [RULE1]
                    v4 = 16'h0000;                             // [RULE1]
                end
                PROF_ROCKER2: begin
                    // first rocker action 0..3 maps to codes 1..4
                    nv = bow ? ext({6'h00, db[POS_R1+1 -: 2]} + 8'h01)
                             : 16'h0000;                       // [RULE4]
                    v4 = {15'h0000, db[POS_SECOND]};           // [RULE6]
                end
                PROF_ROCKER4: begin
                    // three-bit action 0..7 maps to codes 1..8
                    nv = bow ? ext({5'h00, db[POS_R1+2 -: 3]} + 8'h01)
                             : 16'h0000;                       // [RULE5]
                    v4 = {15'h0000, db[POS_SECOND]};           // [RULE6]
                end
                PROF_LIGHT: begin
                    // raw action nibble, already 0x30/0x10/0x70/0x50
                    nv    = bow ? ext({db[7:4], 4'h0}) : 16'h0000; // [RULE7]
                    keep4 = 1'b1;                              // [RULE8]
                end
                PROF_CARD: begin
                    nv = {15'h0000, bow};                      // [RULE9]
                end
                PROF_ALARM: begin
                    nv = {15'h0000, db == DET_ALARM};          // [RULE10]
                    v4 = {15'h0000, db == DET_BATT_LOW};       // [RULE10]
                end
                PROF_WATER: begin
                    nv = {15'h0000, db == DET_WATER};          // [RULE11]
                end
                PROF_HANDLE: begin
                    if (db[7:6] == 2'b11 && db[5:4] == HDL_CLOSED) begin
                        nv = 16'h0000;                         // [RULE12]
                    end else if (db[7:6] == 2'b11 &&
                                 db[5:4] == HDL_TILTED) begin
                        nv = 16'h0002;                         // [RULE12]
                    end else begin
                        nv = 16'h0001;                         // [RULE12]
                    end
                    v4 = ext(db);                              // [RULE12]
                end
                default: begin
                    nv = ext(db);                              // [RULE14]
                    v4 = ext(i_tg.status);                     // [RULE14]
                end
            endcase
            // history shift, oldest first, then the new value lands
            case (p)
                PROF_PUSH, PROF_ROCKER2, PROF_ROCKER4: begin
                    val_nxt[ch][2] = val_r[ch][1];             // [RULE15]
                    val_nxt[ch][1] = val_r[ch][0];             // [RULE15]
                    val_nxt[ch][3] = v4;
                end
                PROF_LIGHT: begin
                    val_nxt[ch][3] = keep4 ? val_r[ch][2]
                                           : 16'h0000;         // [RULE8]
                    val_nxt[ch][2] = val_r[ch][1];             // [RULE8]
                    val_nxt[ch][1] = val_r[ch][0];             // [RULE15]
                end
                PROF_CARD: begin
                    val_nxt[ch][1] = val_r[ch][0];             // [RULE9]
                    val_nxt[ch][2] = 16'h0000;                 // [RULE9]
                    val_nxt[ch][3] = 16'h0000;                 // [RULE9]
                end
                PROF_WATER: begin
                    val_nxt[ch][1] = 16'h0000;
                    val_nxt[ch][2] = 16'h0000;
                    val_nxt[ch][3] = 16'h0000;
                end
                default: begin
                    // alarm, handle and raw profiles use the second slot
                    val_nxt[ch][1] = v4;
                    val_nxt[ch][2] = 16'h0000;
                    val_nxt[ch][3] = 16'h0000;
                end
            endcase
            val_nxt[ch][0] = nv;                               // [RULE15]
        end
    end

    // state registers; the array resets to constants only
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < N_CH; i++) begin
                for (int j = 0; j < 4; j++) begin
                    val_r[i][j] <= VAL_RESET;
                end
                cnt_r[i] <= VAL_RESET;
                dur_r[i] <= DUR_REL;
                tmr_r[i] <= 32'h0000_0000;
            end
            o_rd_valid <= 1'b0;
            o_rd_data  <= VAL_RESET;
        end else begin
            val_r      <= val_nxt;
            cnt_r      <= cnt_nxt;
            dur_r      <= dur_nxt;
            tmr_r      <= tmr_nxt;
            o_rd_valid <= rd_valid_nxt;
            o_rd_data  <= rd_data_nxt;
        end
    end
endmodule : std_decoder
`default_nettype wire

// >>> verif/std_decoder_props.sv
// read-port checker for the switch telegram decoder, bound to it
`timescale 1ns/1ps
`default_nettype none
module std_decoder_props
    import std_pkg::*;
#(
    parameter int N_CH = 4  // receive channels
) (
    input wire logic             i_clk_sys,
    input wire logic             i_arst_n,
    input wire std_cfg_t         i_cfg [N_CH],
    input wire std_tg_t          i_tg,
    input wire std_rd_t          i_rd,
    input wire logic             o_rd_valid,
    input wire logic [VAL_W-1:0] o_rd_data
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    // profile of the channel read; idle or out of range reads as universal
    std_prof_t rp;
    assign rp = (i_rd.stb && i_rd.ch < N_CH) ?
                i_cfg[i_rd.ch].equipment_profile : PROF_UNIVERSAL;
    property p_ans;
        i_rd.stb |=> o_rd_valid;
    endproperty
    a_ans: assert property (p_ans) else $error("read unanswered");
    property p_push;
        rp == PROF_PUSH && i_rd.idx == 3'h3 |=> o_rd_data == 16'h0000;
    endproperty
    a_push: assert property (p_push) else $error("reserved not 0");
    property p_dur;
        rp inside {PROF_PUSH, PROF_ROCKER2, PROF_LIGHT, PROF_ROCKER4}
        && i_rd.idx == IDX_DURATION |=> o_rd_data <= 16'h0002;
    endproperty
    a_dur: assert property (p_dur) else $error("bad duration");
    property p_rk2;
        rp == PROF_ROCKER2 && i_rd.idx < 3'h3 |=> o_rd_data <= 16'h0004;
    endproperty
    a_rk2: assert property (p_rk2) else $error("bad 2-rocker code");
    property p_rk4;
        rp == PROF_ROCKER4 && i_rd.idx < 3'h3 |=> o_rd_data <= 16'h0008;
    endproperty
    a_rk4: assert property (p_rk4) else $error("bad 4-rocker code");
    property p_sec;
        rp inside {PROF_ROCKER2, PROF_ROCKER4} && i_rd.idx == 3'h3
        |=> o_rd_data <= 16'h0001;
    endproperty
    a_sec: assert property (p_sec) else $error("bad second flag");
    property p_card;
        rp == PROF_CARD && i_rd.idx inside {[3'h2:3'h5]}
        |=> o_rd_data == 16'h0000;
    endproperty
    a_card: assert property (p_card) else $error("card value not 0");
    // a clearing read, then a count read of the same channel, no telegram
    property p_clr;
        i_rd.stb && i_rd.idx == IDX_COUNT && i_rd.ch == $past(i_rd.ch, 2)
        && $past(i_rd.stb && i_rd.idx == IDX_CURRENT
                 && i_rd.fn == FN_READ_HOLD, 2)
        && !i_tg.stb && !$past(i_tg.stb) && !$past(i_tg.stb, 2)
        |=> o_rd_data == 16'h0000;
    endproperty
    a_clr: assert property (p_clr) else $error("count not cleared");
    c_long: cover property (rp == PROF_PUSH && i_rd.idx == IDX_DURATION
                            ##1 o_rd_data == 16'h0002);
    c_light: cover property (rp == PROF_LIGHT ##1 o_rd_valid);
    c_card: cover property (rp == PROF_CARD ##1 o_rd_valid);
endmodule : std_decoder_props
bind std_decoder std_decoder_props #(.N_CH(N_CH)) std_decoder_props_inst (
    .i_clk_sys  (i_clk_sys),
    .i_arst_n   (i_arst_n),
    .i_cfg      (i_cfg),
    .i_tg       (i_tg),
    .i_rd       (i_rd),
    .o_rd_valid (o_rd_valid),
    .o_rd_data  (o_rd_data)
);
`default_nettype wire

// >>> verif/std_sender.sv
// behavioural radio switch model driving the decoder telegram strobe
`timescale 1ns/1ps
`default_nettype none
module std_sender
    import std_pkg::*;
(
    input  wire logic    i_clk_sys,
    output var std_tg_t  o_tg
);
    initial begin
        o_tg = '0;
    end
    // one telegram: a one-cycle strobe with its payload
    task send(input logic [7:0] ch, input logic [7:0] ty,
              input logic [7:0] db, input logic [7:0] st);
        @(posedge i_clk_sys);
        o_tg <= {1'b1, ch, ty, db, st};
        @(posedge i_clk_sys);
        // the air carries nothing after a frame, so stale bytes are inverted
        o_tg <= {1'b0, ~ch, ~ty, ~db, ~st};
    endtask : send
endmodule : std_sender
`default_nettype wire

// >>> verif/std_decoder_test.sv
// self-checking bench for the switch telegram decoder
`timescale 1ns/1ps
`default_nettype none
module std_decoder_test import std_pkg::*; ;
    localparam int         LCNT = 20;     // shortened long-press count
    localparam logic [7:0] TY   = 8'hF6;  // switch-class telegram type
    logic             i_clk_sys;
    logic             i_arst_n;
    std_cfg_t         cfg [4];
    std_tg_t          tg;
    std_rd_t          rd;
    logic             o_rd_valid;
    logic [VAL_W-1:0] o_rd_data;
    int               miscompares = 0;
    int               checks = 0;
    int               cyc = 0;
    std_decoder #(.N_CH(4), .LONG_CNT(LCNT)) std_decoder_inst (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_cfg(cfg),
        .i_tg(tg), .i_rd(rd), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
    std_sender std_sender_inst (.i_clk_sys(i_clk_sys), .o_tg(tg));
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    task wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // one read; non-clearing function unless told otherwise
    task rv(input int ch, input logic [2:0] ix, input logic [15:0] ex,
            input logic [7:0] fn = 8'h04);
        @(posedge i_clk_sys);
        rd <= {1'b1, fn, 8'(ch), ix};
        @(posedge i_clk_sys);
        rd.stb <= 1'b0;
        #1;
        checks++;
        if (o_rd_valid !== 1'b1 || o_rd_data !== ex) begin
            miscompares++;
            $display("mismatch ch%0d value%0d expected %h seen %h",
                     ch, ix, ex, o_rd_data);
        end
    endtask : rv
    task tx(input int ch, input logic [7:0] db);
        std_sender_inst.send(8'(ch), TY, db, 8'h00);
    endtask : tx
    task setp(input int ch, input std_prof_t p);
        @(posedge i_clk_sys);
        cfg[ch] <= {TY, p};
    endtask : setp
    task t_push();
        setp(0, PROF_PUSH);
        tx(0, 8'h10);
        tx(0, 8'h00);
        tx(0, 8'h10);
        rv(0, IDX_DURATION, 16'h0001);
        rv(0, IDX_COUNT, 16'h0003);
        rv(0, 3'h1, 16'h0000);
        rv(0, 3'h2, 16'h0001);
        rv(0, 3'h3, 16'h0000);
        rv(0, IDX_CURRENT, 16'h0001, FN_READ_HOLD);
        rv(0, IDX_COUNT, 16'h0000);
        // fresh press, then read just before and just after the long limit
        tx(0, 8'h10);
        repeat (LCNT - 2) @(posedge i_clk_sys);
        rv(0, IDX_DURATION, 16'h0001);
        rv(0, IDX_DURATION, 16'h0002);
        tx(0, 8'h00);
        rv(0, IDX_DURATION, 16'h0000);
    endtask : t_push
    task t_rock();
        setp(1, PROF_ROCKER2);
        setp(2, PROF_ROCKER4);
        for (int k = 0; k < 8; k++) begin
            tx(2, {3'(k), 5'h11});
            rv(2, IDX_CURRENT, 16'(k + 1));
            tx(1, {1'b0, 2'(k), 4'h8, 1'(k)});
            rv(1, IDX_CURRENT, 16'(k % 4 + 1));
            rv(1, 3'h3, 16'(k % 2));
        end
        tx(1, 8'h00);
        rv(1, IDX_CURRENT, 16'h0000);
        rv(1, 3'h2, 16'h0003);
        rv(2, 3'h1, 16'h0007);
    endtask : t_rock
    task t_light();
        setp(3, PROF_LIGHT);
        tx(3, LC_AUTO);
        tx(3, LC_MANUAL);
        tx(3, LC_DIM_UP);
        tx(3, LC_DIM_DOWN);
        rv(3, IDX_CURRENT, 16'h0050);
        rv(3, 3'h1, 16'h0070);
        rv(3, 3'h2, 16'h0010);
        rv(3, 3'h3, 16'h0030);
        rv(3, IDX_COUNT, 16'h0004);
    endtask : t_light
    task t_other();
        setp(0, PROF_CARD);
        tx(0, 8'h10);
        tx(0, 8'h00);
        rv(0, IDX_CURRENT, 16'h0000);
        rv(0, 3'h1, 16'h0001);
        for (int i = 2; i < 6; i++) rv(0, 3'(i), 16'h0000);
        setp(1, PROF_ALARM);
        tx(1, DET_BATT_LOW);
        rv(1, IDX_CURRENT, 16'h0000);
        rv(1, 3'h1, 16'h0001);
        tx(1, DET_ALARM);
        rv(1, IDX_CURRENT, 16'h0001);
        setp(1, PROF_WATER);
        tx(1, DET_WATER);
        rv(1, IDX_CURRENT, 16'h0001);
        tx(1, 8'h00);
        rv(1, IDX_CURRENT, 16'h0000);
        setp(2, PROF_HANDLE);
        tx(2, 8'hD0);
        rv(2, IDX_CURRENT, 16'h0002);
        tx(2, 8'hC0);
        rv(2, IDX_CURRENT, 16'h0001);
        rv(2, 3'h1, 16'h00C0);
        tx(2, 8'hF0);
        rv(2, IDX_CURRENT, 16'h0000);
    endtask : t_other
    task t_univ();
        setp(3, PROF_UNIVERSAL);
        std_sender_inst.send(8'h03, TY, 8'hA5, 8'h3C);
        std_sender_inst.send(8'h03, ~TY, 8'h5A, 8'hC3);
        std_sender_inst.send(8'h04, TY, 8'h5A, 8'hC3);
        rv(3, IDX_CURRENT, 16'h00A5);
        rv(3, 3'h1, 16'h003C);
        rv(3, 3'h6, 16'h0000);
        rv(4, IDX_CURRENT, 16'h0000);
        // a profile code with no decoder falls back to raw data
        setp(3, std_prof_t'(4'h9));
        std_sender_inst.send(8'h03, TY, 8'h66, 8'h99);
        rv(3, IDX_CURRENT, 16'h0066);
        rv(3, 3'h1, 16'h0099);
    endtask : t_univ
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        i_arst_n = 1'b0;
        rd = '0;
        foreach (cfg[c]) cfg[c] = {TY, PROF_UNIVERSAL};
        repeat (16) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        t_push();
        t_rock();
        t_light();
        t_other();
        t_univ();
        wrap_up();
    end
endmodule : std_decoder_test
`default_nettype wire
